// ---- hdl/i2c_assist_port.sv ----
// I2C firmware master assist port with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "i2c_assist_defs.svh"
module i2c_assist_port (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic por_in,
   // AXI4-Lite write address and data
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // I2C lines
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // Processor side
   output logic port_irq_flag_out,
   output logic wake_out
);
   logic [1:0] rst_sync_reg;
   wire rst_n = rst_sync_reg[1];
   logic [1:0] por_sync_reg;
   logic [7:0] transfer_buffer_reg;
   logic [7:0] slave_address_reg;
   logic [7:0] port_control_reg;
   logic [7:0] port_status_reg;
   logic port_irq_flag_reg;
   logic port_irq_enable_reg;
   logic sda_dir_reg;
   logic scl_dir_reg;
   logic sleep_reg;
   logic [4:0] aw_addr_reg;
   logic aw_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic w_held_reg;
   logic wake_reg;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   // No reset here: the buffer clear needs the power-on flag while reset is still held
   always_ff @(posedge clk_in) begin
      por_sync_reg <= {por_sync_reg[0], por_in};
   end

   // Mode decode
   wire [3:0] port_mode_select = port_control_reg[3:0];
   wire port_enable = port_control_reg[`CTL_ENABLE];
   wire fw_master = port_enable && (port_mode_select == `MODE_FW_MASTER ||
      port_mode_select == `MODE_FW_MULTI7 || port_mode_select == `MODE_FW_MULTI10);
   wire slave_on = port_enable && (port_mode_select == `MODE_SLAVE7 || port_mode_select == `MODE_SLAVE10 ||
      port_mode_select == `MODE_FW_MULTI7 || port_mode_select == `MODE_FW_MULTI10);
   wire i2c_on = fw_master || slave_on;

   // Line watch and shifter
   logic scl_level;
   logic sda_level;
   logic scl_rise;
   logic scl_fall;
   i2c_assist_pkg::bus_cond_t cond;
   i2c_line_watch u_watch (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_level_out(scl_level),
      .sda_level_out(sda_level),
      .scl_rise_out(scl_rise),
      .scl_fall_out(scl_fall),
      .cond_out(cond)
   );
   logic [7:0] rx_byte;
   logic byte_done;
   logic first_byte;
   logic ack_drive;
   wire buf_full = port_status_reg[`STA_FULL];
   wire overflow = port_control_reg[`CTL_OVERFLOW];
   wire addr_match = first_byte && (rx_byte[7:1] == slave_address_reg[7:1]);
   // Slave keeps listening even after this master lost arbitration
   wire ack_now = slave_on && !buf_full && !overflow && (addr_match || !first_byte);
   i2c_byte_shifter u_shift (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .active_in(i2c_on),
      .scl_rise_in(scl_rise),
      .scl_fall_in(scl_fall),
      .sda_in(sda_level),
      .cond_in(cond),
      .ack_in(ack_now),
      .byte_out(rx_byte),
      .byte_done_out(byte_done),
      .first_byte_out(first_byte),
      .ack_drive_out(ack_drive)
   );
   wire byte_event = i2c_on && byte_done && (fw_master || !first_byte || addr_match);
   wire take_byte = byte_event && slave_on && !buf_full;
   wire start_event = i2c_on && cond == i2c_assist_pkg::COND_START;
   wire stop_event = i2c_on && cond == i2c_assist_pkg::COND_STOP;
   // Stop and start always flag in master modes, so a busy bus reports its release
   wire irq_set = byte_event || (fw_master && (start_event || stop_event));

   // AXI4-Lite decode
   wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire rd_go = s_axi_arvalid && s_axi_arready;
   wire wr_buf = wr_go && aw_addr_reg == 5'(`OFS_BUFFER) && w_strb_reg[0];
   wire wr_adr = wr_go && aw_addr_reg == 5'(`OFS_ADDRESS) && w_strb_reg[0];
   wire wr_ctl = wr_go && aw_addr_reg == 5'(`OFS_CONTROL) && w_strb_reg[0];
   wire wr_sta = wr_go && aw_addr_reg == 5'(`OFS_STATUS) && w_strb_reg[0];
   wire wr_pin = wr_go && aw_addr_reg == `OFS_PINS && w_strb_reg[0];
   wire wr_hit = aw_addr_reg[1:0] == 2'h0 && aw_addr_reg <= `OFS_PINS;
   wire [4:0] ra = s_axi_araddr;
   wire rd_hit = ra[1:0] == 2'h0 && ra <= `OFS_PINS;
   wire rd_buf = rd_go && ra == 5'(`OFS_BUFFER);
   wire [7:0] pin_view = {3'h0, sleep_reg, scl_dir_reg, sda_dir_reg, port_irq_enable_reg, port_irq_flag_reg};
   wire [7:0] rd_byte = (ra == 5'(`OFS_BUFFER)) ? transfer_buffer_reg :
      (ra == 5'(`OFS_ADDRESS)) ? slave_address_reg :
      (ra == 5'(`OFS_CONTROL)) ? port_control_reg :
      (ra == 5'(`OFS_STATUS)) ? port_status_reg :
      (ra == `OFS_PINS) ? pin_view : 8'h00;

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         aw_addr_reg <= 5'h00;
         w_data_reg <= 32'h0;
         w_strb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_reg <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rd_byte};
            s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Registers other than the buffer; all clear on any reset
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         slave_address_reg <= `RESET_BYTE;
         port_irq_enable_reg <= 1'b0;
         sda_dir_reg <= 1'b0;
         scl_dir_reg <= 1'b0;
         sleep_reg <= 1'b0;
      end else begin
         if (wr_adr) begin
            slave_address_reg <= w_data_reg[7:0];
         end
         if (wr_pin) begin
            port_irq_enable_reg <= w_data_reg[`PIN_IRQ_ENABLE];
            sda_dir_reg <= w_data_reg[`PIN_SDA_DIR];
            scl_dir_reg <= w_data_reg[`PIN_SCL_DIR];
            sleep_reg <= w_data_reg[`PIN_SLEEP];
         end
      end
   end
   // Buffer keeps its value on a warm reset, loads zero on power-on
   always_ff @(posedge clk_in) begin
      if (!rst_n && por_sync_reg[1]) begin
         transfer_buffer_reg <= `RESET_BYTE;
      end else if (wr_buf) begin
         transfer_buffer_reg <= w_data_reg[7:0];
      end else if (take_byte) begin
         transfer_buffer_reg <= rx_byte;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         port_control_reg <= `RESET_BYTE;
      end else begin
         port_control_reg[3:0] <= wr_ctl ? w_data_reg[3:0] : port_control_reg[3:0];
         port_control_reg[`CTL_ENABLE] <= wr_ctl ? w_data_reg[`CTL_ENABLE] : port_enable;
         // Clock release by software only
         port_control_reg[`CTL_CLK_RELEASE] <= wr_ctl ? w_data_reg[`CTL_CLK_RELEASE] :
            port_control_reg[`CTL_CLK_RELEASE];
         port_control_reg[`CTL_OVERFLOW] <= (byte_event && slave_on && buf_full) ||
            (!wr_ctl && overflow) || (wr_ctl && w_data_reg[`CTL_OVERFLOW]);
         port_control_reg[`CTL_WCOL] <= (wr_buf && ack_drive) ||
            (!wr_ctl && port_control_reg[`CTL_WCOL]) || (wr_ctl && w_data_reg[`CTL_WCOL]);
      end
   end
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         port_status_reg <= `RESET_BYTE;
      end else begin
         // SPI sample phase and clock edge bits, writable
         if (wr_sta) begin
            port_status_reg[`STA_SAMPLE_PHASE] <= w_data_reg[`STA_SAMPLE_PHASE];
            port_status_reg[`STA_CLK_EDGE] <= w_data_reg[`STA_CLK_EDGE];
         end
         if (!port_enable) begin
            port_status_reg[`STA_STOP] <= 1'b0;
            port_status_reg[`STA_START] <= 1'b0;
         end else if (start_event) begin
            port_status_reg[`STA_START] <= 1'b1;
            port_status_reg[`STA_STOP] <= 1'b0;
         end else if (stop_event) begin
            port_status_reg[`STA_STOP] <= 1'b1;
            port_status_reg[`STA_START] <= 1'b0;
         end
         if (take_byte) begin
            port_status_reg[`STA_DATA_ADDR] <= !first_byte;
            if (first_byte) begin
               port_status_reg[`STA_READ_WRITE] <= rx_byte[0];
            end
         end
         if (take_byte) begin
            port_status_reg[`STA_FULL] <= 1'b1;
         end else if (rd_buf) begin
            port_status_reg[`STA_FULL] <= 1'b0;
         end
      end
   end
   // Interrupt flag: hardware set wins over software clear
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         port_irq_flag_reg <= 1'b0;
         wake_reg <= 1'b0;
      end else begin
         port_irq_flag_reg <= irq_set || (port_irq_flag_reg && !(wr_pin && !w_data_reg[`PIN_IRQ_FLAG]));
         wake_reg <= sleep_reg && port_irq_enable_reg && irq_set;
      end
   end

   // Pin drive: output direction drives low in firmware master modes only
   wire sda_low = (fw_master && sda_dir_reg) || ack_drive;
   wire scl_low = (fw_master && scl_dir_reg) ||
      (slave_on && !port_control_reg[`CTL_CLK_RELEASE] && port_status_reg[`STA_FULL]);
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe_out <= 1'b0;
         scl_oe_out <= 1'b0;
         port_irq_flag_out <= 1'b0;
         wake_out <= 1'b0;
      end else begin
         sda_oe_out <= sda_low;
         scl_oe_out <= scl_low;
         port_irq_flag_out <= port_irq_flag_reg;
         wake_out <= wake_reg;
      end
   end
   assign sda_out = 1'b0;
   assign scl_out = 1'b0;
endmodule : i2c_assist_port

// ---- hdl/i2c_byte_shifter.sv ----
// Counts bits of each byte, shifts received bits and answers the acknowledge slot
`timescale 1ns/1ps
module i2c_byte_shifter (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Line events
   input wire logic active_in,
   input wire logic scl_rise_in,
   input wire logic scl_fall_in,
   input wire logic sda_in,
   input wire i2c_assist_pkg::bus_cond_t cond_in,
   input wire logic ack_in,
   // Results
   output logic [7:0] byte_out,
   output logic byte_done_out,
   output logic first_byte_out,
   output logic ack_drive_out
);
   i2c_assist_pkg::shift_state_t state_reg;
   logic [7:0] shift_reg;
   logic [3:0] count_reg;
   logic first_reg;
   wire restart = cond_in != i2c_assist_pkg::COND_NONE;
   assign byte_out = shift_reg;
   assign first_byte_out = first_reg;
   assign byte_done_out = (state_reg == i2c_assist_pkg::SH_SHIFT) && scl_fall_in && (count_reg == 4'h8);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= i2c_assist_pkg::SH_IDLE;
         shift_reg <= 8'h00;
         count_reg <= 4'h0;
         first_reg <= 1'b0;
         ack_drive_out <= 1'b0;
      end else if (!active_in || cond_in == i2c_assist_pkg::COND_STOP) begin
         state_reg <= i2c_assist_pkg::SH_IDLE;
         count_reg <= 4'h0;
         ack_drive_out <= 1'b0;
      end else if (restart) begin
         state_reg <= i2c_assist_pkg::SH_SHIFT;
         count_reg <= 4'h0;
         first_reg <= 1'b1;
         ack_drive_out <= 1'b0;
      end else begin
         case (state_reg)
            i2c_assist_pkg::SH_IDLE: begin
               count_reg <= 4'h0;
            end
            i2c_assist_pkg::SH_SHIFT: begin
               if (scl_rise_in) begin
                  shift_reg <= {shift_reg[6:0], sda_in};
                  count_reg <= count_reg + 4'h1;
               end
               if (byte_done_out) begin
                  state_reg <= i2c_assist_pkg::SH_ACK;
                  ack_drive_out <= ack_in;
               end
            end
            i2c_assist_pkg::SH_ACK: begin
               if (scl_fall_in) begin
                  ack_drive_out <= 1'b0;
                  count_reg <= 4'h0;
                  first_reg <= 1'b0;
                  state_reg <= i2c_assist_pkg::SH_SHIFT;
               end
            end
            default: begin
               state_reg <= i2c_assist_pkg::SH_IDLE;
            end
         endcase
      end
   end
endmodule : i2c_byte_shifter

// ---- hdl/i2c_line_watch.sv ----
// Synchronises SCL and SDA and reports edges and bus conditions
`timescale 1ns/1ps
module i2c_line_watch (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Raw lines
   input wire logic scl_in,
   input wire logic sda_in,
   // Conditions
   output logic scl_level_out,
   output logic sda_level_out,
   output logic scl_rise_out,
   output logic scl_fall_out,
   output i2c_assist_pkg::bus_cond_t cond_out
);
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_in};
         sda_sync_reg <= {sda_sync_reg[0], sda_in};
         scl_prev_reg <= scl_sync_reg[1];
         sda_prev_reg <= sda_sync_reg[1];
      end
   end
   assign scl_level_out = scl_sync_reg[1];
   assign sda_level_out = sda_sync_reg[1];
   assign scl_rise_out = scl_sync_reg[1] & ~scl_prev_reg;
   assign scl_fall_out = ~scl_sync_reg[1] & scl_prev_reg;
   // Conditions only while SCL stays high
   wire both_high = scl_sync_reg[1] & scl_prev_reg;
   assign cond_out = (both_high & sda_prev_reg & ~sda_sync_reg[1]) ? i2c_assist_pkg::COND_START :
      (both_high & ~sda_prev_reg & sda_sync_reg[1]) ? i2c_assist_pkg::COND_STOP : i2c_assist_pkg::COND_NONE;
endmodule : i2c_line_watch

// ---- pkg/i2c_assist_defs.svh ----
// Register offsets, field positions, reset values and mode codes of the I2C assist port
`ifndef I2C_ASSIST_DEFS_SVH
`define I2C_ASSIST_DEFS_SVH
`define OFS_BUFFER 4'h0
`define OFS_ADDRESS 4'h4
`define OFS_CONTROL 4'h8
`define OFS_STATUS 4'hc
`define OFS_PINS 5'h10
`define CTL_WCOL 7
`define CTL_OVERFLOW 6
`define CTL_ENABLE 5
`define CTL_CLK_RELEASE 4
`define STA_SAMPLE_PHASE 7
`define STA_CLK_EDGE 6
`define STA_DATA_ADDR 5
`define STA_STOP 4
`define STA_START 3
`define STA_READ_WRITE 2
`define STA_UPDATE_ADDR 1
`define STA_FULL 0
`define PIN_IRQ_FLAG 0
`define PIN_IRQ_ENABLE 1
`define PIN_SDA_DIR 2
`define PIN_SCL_DIR 3
`define PIN_SLEEP 4
`define RESET_BYTE 8'h00
`define MODE_FW_MASTER 4'hb
`define MODE_FW_MULTI7 4'he
`define MODE_FW_MULTI10 4'hf
`define MODE_SLAVE7 4'h6
`define MODE_SLAVE10 4'h7
`endif

// ---- pkg/i2c_assist_pkg.sv ----
// Types shared by the I2C assist port
package i2c_assist_pkg;
   typedef enum logic [1:0] {
      COND_NONE,
      COND_START,
      COND_STOP
   } bus_cond_t;
   typedef enum logic [1:0] {
      SH_IDLE,
      SH_SHIFT,
      SH_ACK
   } shift_state_t;
endpackage : i2c_assist_pkg

// ---- verif/i2c_assist_port_test.sv ----
// Self-checking bench for the I2C assist port
`timescale 1ns/1ps
`include "i2c_assist_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module i2c_assist_port_test;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic por_in = 1'b1;
   logic [4:0] s_axi_awaddr = 5'h00;
   logic [4:0] s_axi_araddr = 5'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic scl_out, sda_out, scl_oe_out, sda_oe_out, port_irq_flag_out, wake_out;
   logic scl_low, sda_low, scl_line, sda_line;
   logic wake_seen = 1'b0;
   logic ack_seen = 1'b0;
   logic [3:0] modes [3] = '{`MODE_FW_MASTER, `MODE_FW_MULTI7, `MODE_FW_MULTI10};
   int err_count = 0;
   int check_count = 0;
   always #5 clk_in = !clk_in;
   assign scl_line = !(scl_oe_out || scl_low);
   assign sda_line = !(sda_oe_out || sda_low);
   always @(posedge clk_in) if (wake_out === 1'b1) wake_seen <= 1'b1;
   always @(posedge clk_in) if (sda_oe_out === 1'b1) ack_seen <= 1'b1;
   i2c_assist_port i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .por_in(por_in),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_in(scl_line), .scl_out(scl_out),
      .scl_oe_out(scl_oe_out), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
      .port_irq_flag_out(port_irq_flag_out), .wake_out(wake_out));
   i2c_bus_peer i_peer (.scl_in(scl_line), .sda_in(sda_line), .scl_low_out(scl_low), .sda_low_out(sda_low));
   task automatic end_sim();
      if (err_count == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cyc
   task automatic do_reset(input logic p);
      if (por_in !== p) begin
         por_in <= p;
         cyc(3);
      end
      reset_n_in <= 1'b0;
      cyc(12);
      reset_n_in <= 1'b1;
      cyc(3);
   endtask : do_reset
   task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r = 2'b00);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 60);
      s_axi_bready <= 1'b0;
      if (n >= 60) begin
         err_count++;
         end_sim();
      end
      `CHK(s_axi_bresp, r)
      @(posedge clk_in);
   endtask : wr
   // Compares the masked low byte and the response code
   task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e, input logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 60);
      s_axi_rready <= 1'b0;
      if (n >= 60) begin
         err_count++;
         end_sim();
      end
      `CHK(s_axi_rdata[7:0] & m, e)
      `CHK(s_axi_rresp, r)
      @(posedge clk_in);
   endtask : rd
   initial begin
      do_reset(1'b1);
      rd(`OFS_CONTROL, 8'hff, 8'h00, 2'b00);
      rd(`OFS_STATUS, 8'hff, 8'h00, 2'b00);
      rd(`OFS_ADDRESS, 8'hff, 8'h00, 2'b00);
      rd(5'h14, 8'h00, 8'h00, 2'b10);
      wr(5'h14, 8'hff, 2'b10);
      wr(`OFS_BUFFER, 8'ha5);
      wr(`OFS_ADDRESS, 8'h5a);
      wr(`OFS_CONTROL, 8'h2b);
      do_reset(1'b0);
      rd(`OFS_BUFFER, 8'hff, 8'ha5, 2'b00);
      rd(`OFS_ADDRESS, 8'hff, 8'h00, 2'b00);
      rd(`OFS_CONTROL, 8'hff, 8'h00, 2'b00);
      do_reset(1'b1);
      rd(`OFS_BUFFER, 8'hff, 8'h00, 2'b00);
      wr(`OFS_STATUS, 8'hc0);
      rd(`OFS_STATUS, 8'hc0, 8'hc0, 2'b00);
      wr(`OFS_STATUS, 8'h00);
      rd(`OFS_STATUS, 8'hc0, 8'h00, 2'b00);
      wr(`OFS_ADDRESS, 8'h3c);
      foreach (modes[k]) begin
         wr(`OFS_CONTROL, {4'h3, modes[k]});
         wr(`OFS_PINS, 8'h02);
         i_peer.start_cond();
         cyc(8);
         `CHK(port_irq_flag_out, 1'b1)
         rd(`OFS_STATUS, 8'h18, 8'h08, 2'b00);
         wr(`OFS_PINS, 8'h02);
         i_peer.put_byte(8'h3c);
         cyc(8);
         `CHK(port_irq_flag_out, 1'b1)
         wr(`OFS_PINS, 8'h02);
         i_peer.stop_cond();
         cyc(8);
         `CHK(port_irq_flag_out, 1'b1)
         rd(`OFS_STATUS, 8'h18, 8'h10, 2'b00);
         wr(`OFS_CONTROL, 8'h00);
         rd(`OFS_STATUS, 8'h18, 8'h00, 2'b00);
      end
      `CHK(ack_seen, 1'b1)
      wr(`OFS_CONTROL, 8'h3b);
      wr(`OFS_PINS, 8'h0c);
      cyc(3);
      `CHK({scl_oe_out, sda_oe_out, scl_line, sda_line}, 4'b1100)
      wr(`OFS_PINS, 8'h00);
      cyc(3);
      `CHK({scl_oe_out, sda_oe_out, scl_line, sda_line}, 4'b0011)
      wr(`OFS_PINS, 8'h12);
      i_peer.start_cond();
      cyc(8);
      `CHK(wake_seen, 1'b1)
      i_peer.stop_cond();
      cyc(4);
      end_sim();
   end
   initial begin
      #200000;
      err_count++;
      end_sim();
   end
endmodule : i2c_assist_port_test
bind i2c_assist_port i2c_assist_sva i_sva (.clk_in(clk_in), .reset_n_in(reset_n_in), .scl_in(scl_in),
   .sda_in(sda_in), .scl_out(scl_out), .sda_out(sda_out), .port_irq_flag_out(port_irq_flag_out),
   .wake_out(wake_out), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ---- verif/i2c_assist_sva.sv ----
// Concurrent checks on the boundary of the I2C assist port
`timescale 1ns/1ps
module i2c_assist_sva (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // Bus lines
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic scl_out,
   input wire logic sda_out,
   // Processor side
   input wire logic port_irq_flag_out,
   input wire logic wake_out,
   // Register bus
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   logic scl_q;
   logic sda_q;
   logic [4:0] quiet_reg;
   // Cycles since either line last moved, saturating
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         quiet_reg <= 5'h1f;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         if (scl_q != scl_in || sda_q != sda_in) quiet_reg <= 5'h00;
         else if (quiet_reg != 5'h1f) quiet_reg <= quiet_reg + 5'h01;
      end
   end
   sda_drive_low_a: assert property (sda_out == 1'b0) else $error("sda driven high");
   scl_drive_low_a: assert property (scl_out == 1'b0) else $error("scl driven high");
   irq_cause_a: assert property ($rose(port_irq_flag_out) |-> quiet_reg < 5'h0c)
      else $error("interrupt without a bus event");
   wake_irq_a: assert property ($rose(wake_out) |-> ##[0:2] port_irq_flag_out)
      else $error("wake without interrupt");
   read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
   write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
   bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
      else $error("bad write response");
   awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
   cover property ($rose(wake_out));
   cover property ($rose(port_irq_flag_out));
   cover property (s_axi_rvalid && s_axi_rready);
endmodule : i2c_assist_sva

// ---- verif/i2c_bus_peer.sv ----
// Behavioural far-side I2C master pulling the wired lines low
`timescale 1ns/1ps
module i2c_bus_peer (
   // Wired levels
   input wire logic scl_in,
   input wire logic sda_in,
   // Pull-down requests
   output logic scl_low_out,
   output logic sda_low_out
);
   localparam int HALF_NS = 80;
   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
   end
   // Release SCL and wait, bounded, while anyone stretches it
   task automatic scl_high();
      int n;
      n = 0;
      scl_low_out = 1'b0;
      while (scl_in !== 1'b1 && n < 100) begin
         #10;
         n++;
      end
      #(HALF_NS);
   endtask : scl_high
   // Only called on an idle bus; SDA falls while SCL is high
   task automatic start_cond();
      #1;
      sda_low_out = 1'b1;
      #(HALF_NS);
      scl_low_out = 1'b1;
   endtask : start_cond
   // Ones float, zeros pull; ninth bit left free for acknowledge
   task automatic put_byte(input logic [7:0] b);
      logic [8:0] w;
      #1;
      w = {b, 1'b1};
      for (int i = 8; i >= 0; i--) begin
         sda_low_out = !w[i];
         #(HALF_NS);
         scl_high();
         if (i > 0 && w[i] && sda_in !== 1'b1) begin
            sda_low_out = 1'b0;
            return; // caller does not retry the transfer
         end
         scl_low_out = 1'b1;
      end
   endtask : put_byte
   // SDA rises while SCL is high, then the clock stands still
   task automatic stop_cond();
      #1;
      sda_low_out = 1'b1;
      #(HALF_NS);
      scl_high();
      sda_low_out = 1'b0;
      #(HALF_NS);
   endtask : stop_cond
endmodule : i2c_bus_peer
